//--- logic/bss_pkg.sv
// constants and types for the boot source selector
package bss_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RESTART_MS = 3;
  localparam int unsigned SHORT_WIN_MS = 100;
  localparam int unsigned LONG_WIN_S = 60;
  localparam longint unsigned RESTART_CYC = longint'(CLK_HZ) / 1000 * RESTART_MS;
  localparam longint unsigned SHORT_WIN_CYC = longint'(CLK_HZ) / 1000 * SHORT_WIN_MS;
  localparam longint unsigned LONG_WIN_CYC = longint'(CLK_HZ) * LONG_WIN_S;
  localparam int CNT_W = 33;

  typedef enum logic [2:0] {
    BSS_MODE_SERIAL,      // long serial window only
    BSS_MODE_SER_FLASH,   // short window then flash
    BSS_MODE_FLASH_ONLY,  // flash, shutdown on failure
    BSS_MODE_SD_SERIAL,   // sd, long window on failure
    BSS_MODE_SD_ONLY      // sd, shutdown on failure
  } bss_mode_t;

  typedef struct packed {
    logic flash_boot_select;
    logic select_pullup_switch;
    logic select_pulldown_switch;
    logic card_present;
  } bss_straps_t;

  typedef struct packed {
    logic serial_active;
    logic flash_active;
    logic sd_active;
    logic core_run;
    logic shutdown;
  } bss_status_t;
endpackage

//--- logic/bss_boot_selector.sv
// boot source sequencer with status led power gating
`timescale 1ns/1ps
module bss_boot_selector #(
  parameter longint unsigned RESTART_CYCLES = bss_pkg::RESTART_CYC,   // restart delay
  parameter longint unsigned SHORT_WIN_CYCLES = bss_pkg::SHORT_WIN_CYC, // short serial window
  parameter longint unsigned LONG_WIN_CYCLES = bss_pkg::LONG_WIN_CYC  // long serial window
) (
  input wire logic sys_clk, // 100 mhz clock
  input wire logic rst_b, // sync reset, active low
  input wire logic reset_in_low, // external reset pin level
  input wire bss_pkg::bss_straps_t straps, // strap switches and card detect
  input wire logic serial_loaded, // pulse: serial load finished
  input wire logic boot_ok, // pulse: flash or sd load succeeded
  input wire logic boot_fail, // pulse: flash or sd load failed
  input wire logic led_line_a, // led line a level
  input wire logic led_line_b, // led line b level
  input wire logic led_enable_switch, // led power switch
  output logic led_a_on, // led a lit
  output logic led_b_on, // led b lit
  output logic io_oe, // controller drives i/o lines
  output bss_pkg::bss_status_t status, // boot progress
  output bss_pkg::bss_mode_t mode // decoded boot mode
);
  typedef enum {ST_RESET, ST_DELAY, ST_SAMPLE, ST_SHORT, ST_FLASH, ST_SD, ST_LONG, ST_RUN, ST_DOWN} bss_state_t;

  bss_state_t state_reg;
  logic [bss_pkg::CNT_W-1:0] cnt_reg;
  logic in_reset;

  // decode straps to mode; pull-up wins, both-on is caller error
  function automatic bss_pkg::bss_mode_t decode(input bss_pkg::bss_straps_t s);
    if (s.select_pullup_switch && !s.select_pulldown_switch)
      decode = bss_pkg::BSS_MODE_SERIAL;
    else if (s.flash_boot_select && s.select_pulldown_switch)
      decode = bss_pkg::BSS_MODE_FLASH_ONLY;
    else if (s.flash_boot_select)
      decode = bss_pkg::BSS_MODE_SER_FLASH;
    else if (s.select_pulldown_switch)
      decode = bss_pkg::BSS_MODE_SD_ONLY;
    else if (s.card_present)
      decode = bss_pkg::BSS_MODE_SD_SERIAL;
    else
      decode = bss_pkg::BSS_MODE_SERIAL;
  endfunction

  // restart delay spent; the sequencer and the strap latch share it so that
  // the straps are taken on exactly the edge on which sampling begins
  function automatic logic delay_done(input logic [bss_pkg::CNT_W-1:0] c);
    delay_done = (c >= RESTART_CYCLES[bss_pkg::CNT_W-1:0] - 2'd2);
  endfunction

  // either reset source restarts the boot; the pin is taken as synchronous
  assign in_reset = !rst_b || !reset_in_low;

  // sequencer; any reset restarts evaluation from scratch
  always_ff @(posedge sys_clk)
  begin
    if (in_reset)
    begin
      state_reg <= ST_RESET;
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
      case (state_reg)
        ST_RESET:
        begin
          state_reg <= ST_DELAY;
          cnt_reg <= '0;
        end
        ST_DELAY:
          if (delay_done(cnt_reg))
            state_reg <= ST_SAMPLE;
        ST_SAMPLE:
        begin
          cnt_reg <= '0;
          case (mode)
            bss_pkg::BSS_MODE_SER_FLASH: state_reg <= ST_SHORT;
            bss_pkg::BSS_MODE_FLASH_ONLY: state_reg <= ST_FLASH;
            bss_pkg::BSS_MODE_SD_SERIAL, bss_pkg::BSS_MODE_SD_ONLY: state_reg <= ST_SD;
            default: state_reg <= ST_LONG;
          endcase
        end
        ST_SHORT:
          if (serial_loaded)
            state_reg <= ST_RUN;
          else if (cnt_reg >= SHORT_WIN_CYCLES[bss_pkg::CNT_W-1:0] - 1'b1)
            state_reg <= ST_FLASH;
        ST_FLASH, ST_SD:
        begin
          cnt_reg <= '0;
          if (boot_ok)
            state_reg <= ST_RUN;
          else if (boot_fail)
            state_reg <= (mode == bss_pkg::BSS_MODE_FLASH_ONLY || mode == bss_pkg::BSS_MODE_SD_ONLY)
                         ? ST_DOWN : ST_LONG;
        end
        ST_LONG:
          if (serial_loaded)
            state_reg <= ST_RUN;
          else if (cnt_reg >= LONG_WIN_CYCLES[bss_pkg::CNT_W-1:0] - 1'b1)
            state_reg <= ST_DOWN;
        ST_RUN: cnt_reg <= '0;
        ST_DOWN: cnt_reg <= '0;
        default: state_reg <= ST_RESET;
      endcase
    end
  end

  // straps latched once, while lines still float
  always_ff @(posedge sys_clk)
  begin
    if (in_reset)
      mode <= bss_pkg::BSS_MODE_SERIAL;
    else if (state_reg == ST_DELAY && delay_done(cnt_reg))
      mode <= decode(straps);
  end

  // registered status; lines released during reset and sampling
  always_ff @(posedge sys_clk)
  begin
    if (in_reset)
    begin
      status <= '0;
      io_oe <= 1'b0;
    end
    else
    begin
      status.serial_active <= (state_reg == ST_SHORT || state_reg == ST_LONG);
      status.flash_active <= (state_reg == ST_FLASH);
      status.sd_active <= (state_reg == ST_SD);
      status.core_run <= (state_reg == ST_RUN);
      status.shutdown <= (state_reg == ST_DOWN);
      io_oe <= (state_reg == ST_RUN);
    end
  end

  // led buffer: only sees the lines, switch cuts power
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      led_a_on <= 1'b0;
      led_b_on <= 1'b0;
    end
    else
    begin
      led_a_on <= led_enable_switch && led_line_a;
      led_b_on <= led_enable_switch && led_line_b;
    end
  end

  // led buffer: follows its line one cycle late, dark without power
  a_led_dark_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !led_enable_switch |=> !led_a_on && !led_b_on) else $error("led lit while power off");
  a_led_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    led_enable_switch && led_line_a |=> led_a_on) else $error("led a not following line");
  a_led_b_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    led_enable_switch && led_line_b |=> led_b_on) else $error("led b not following line");
  a_led_a_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !led_line_a |=> !led_a_on) else $error("led a lit with line low");
  a_led_b_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !led_line_b |=> !led_b_on) else $error("led b lit with line low");

  // lines float and status clears under either reset
  a_float_reset: assert property (@(posedge sys_clk)
    !reset_in_low |=> !io_oe && !status.core_run) else $error("lines driven in reset");
  a_reset_quiet: assert property (@(posedge sys_clk)
    !rst_b |=> status == '0 && !io_oe) else $error("status or lines active in reset");
  a_io_run_only: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg != ST_RUN |=> !io_oe) else $error("lines driven outside run");

  // mode is taken once and does not move until the next reset
  a_mode_stable: assert property (@(posedge sys_clk) disable iff (in_reset)
    (state_reg == ST_LONG || state_reg == ST_FLASH || state_reg == ST_SD) |=> $stable(mode))
    else $error("mode changed mid boot");
  a_mode_held: assert property (@(posedge sys_clk) disable iff (in_reset)
    (state_reg == ST_SHORT || state_reg == ST_RUN || state_reg == ST_DOWN) |=> $stable(mode))
    else $error("mode changed after boot");

  // first boot step chosen from the decoded mode
  a_pullup_serial: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SAMPLE && mode == bss_pkg::BSS_MODE_SERIAL |=> state_reg == ST_LONG)
    else $error("serial mode skipped window");
  a_sample_short: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SAMPLE && mode == bss_pkg::BSS_MODE_SER_FLASH |=> state_reg == ST_SHORT)
    else $error("flash mode skipped short window");
  a_sample_flash: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SAMPLE && mode == bss_pkg::BSS_MODE_FLASH_ONLY |=> state_reg == ST_FLASH)
    else $error("flash only opened a window");
  a_sample_sd: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SAMPLE && (mode == bss_pkg::BSS_MODE_SD_SERIAL || mode == bss_pkg::BSS_MODE_SD_ONLY)
    |=> state_reg == ST_SD) else $error("card mode did not start card load");

  // outcome of each load attempt and of the windows
  a_flash_down: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_FLASH && mode == bss_pkg::BSS_MODE_FLASH_ONLY && boot_fail && !boot_ok
    |=> state_reg == ST_DOWN) else $error("flash only did not shut down");
  a_flash_fallback: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_FLASH && mode == bss_pkg::BSS_MODE_SER_FLASH && boot_fail && !boot_ok
    |=> state_reg == ST_LONG) else $error("flash fail missed window");
  a_sd_fallback: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SD && mode == bss_pkg::BSS_MODE_SD_SERIAL && boot_fail && !boot_ok
    |=> state_reg == ST_LONG ##1 status.serial_active) else $error("sd fail missed window");
  a_sd_only_down: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SD && mode == bss_pkg::BSS_MODE_SD_ONLY && boot_fail && !boot_ok
    |=> state_reg == ST_DOWN) else $error("sd only did not shut down");
  a_short_to_flash: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_SHORT && !serial_loaded && cnt_reg == SHORT_WIN_CYCLES[bss_pkg::CNT_W-1:0] - 1'b1
    |=> state_reg == ST_FLASH) else $error("short window overran");
  a_long_expire: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_LONG && !serial_loaded && cnt_reg == LONG_WIN_CYCLES[bss_pkg::CNT_W-1:0] - 1'b1
    |=> state_reg == ST_DOWN) else $error("long window overran");
  a_down_final: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_DOWN |=> state_reg == ST_DOWN)
    else $error("shutdown left without reset");
  a_restart_hold: assert property (@(posedge sys_clk) disable iff (in_reset)
    state_reg == ST_RESET |=> state_reg == ST_DELAY ##1 state_reg != ST_SAMPLE)
    else $error("boot started early");
endmodule

//--- dv/bss_loader_model.sv
// far side model: flash, sd card and serial host
`timescale 1ns/1ps
module bss_loader_model (
  input wire logic sys_clk, // clock
  input wire bss_pkg::bss_status_t status, // boot progress
  input wire logic fail_cmd, // media load fails
  input wire logic load_cmd, // host sends a load
  output logic boot_ok = 1'b0, // media load good
  output logic boot_fail = 1'b0, // media load bad
  output logic serial_loaded = 1'b0 // host load done
);
  logic [7:0] mem_cnt_reg = 8'h00;
  logic [7:0] ser_cnt_reg = 8'h00;
  // media answers once, 3 cycles into its phase
  always_ff @(posedge sys_clk)
  begin
    mem_cnt_reg <= (status.flash_active || status.sd_active) ? mem_cnt_reg + 8'h01 : 8'h00;
    boot_ok <= (mem_cnt_reg == 8'h03) && !fail_cmd;
    boot_fail <= (mem_cnt_reg == 8'h03) && fail_cmd;
  end
  // host is slow: misses the short window, fits the long one
  always_ff @(posedge sys_clk)
  begin
    ser_cnt_reg <= status.serial_active ? ser_cnt_reg + 8'h01 : 8'h00;
    serial_loaded <= (ser_cnt_reg == 8'h0f) && load_cmd;
  end
endmodule

//--- dv/testbench.sv
// self-checking bench for the boot source selector
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [3:0] st; logic fl; logic ld; bss_pkg::bss_mode_t md; logic run;} bss_row_t;
  logic sys_clk, rst_b, reset_in_low, fail_cmd, load_cmd, led_line_a, led_line_b, led_enable_switch;
  logic serial_loaded, boot_ok, boot_fail, led_a_on, led_b_on, io_oe;
  bss_pkg::bss_straps_t straps;
  bss_pkg::bss_status_t status;
  bss_pkg::bss_mode_t mode;
  int fails = 0;
  int checks = 0;
  // straps {flash, up, down, card}, media fails, host loads, mode, ends running
  bss_row_t rows [7] = '{
    '{4'h0, 1'b0, 1'b0, bss_pkg::BSS_MODE_SERIAL, 1'b0},
    '{4'hc, 1'b0, 1'b1, bss_pkg::BSS_MODE_SERIAL, 1'b1},
    '{4'h8, 1'b1, 1'b1, bss_pkg::BSS_MODE_SER_FLASH, 1'b1},
    '{4'ha, 1'b1, 1'b0, bss_pkg::BSS_MODE_FLASH_ONLY, 1'b0},
    '{4'h1, 1'b1, 1'b1, bss_pkg::BSS_MODE_SD_SERIAL, 1'b1},
    '{4'h2, 1'b0, 1'b0, bss_pkg::BSS_MODE_SD_ONLY, 1'b1},
    '{4'h2, 1'b1, 1'b0, bss_pkg::BSS_MODE_SD_ONLY, 1'b0}};
  // short counts keep each boot to a few dozen cycles
  bss_boot_selector #(.RESTART_CYCLES(20), .SHORT_WIN_CYCLES(10), .LONG_WIN_CYCLES(40)) i_bss_boot_selector (
    .sys_clk(sys_clk), .rst_b(rst_b), .reset_in_low(reset_in_low), .straps(straps),
    .serial_loaded(serial_loaded), .boot_ok(boot_ok), .boot_fail(boot_fail), .led_line_a(led_line_a),
    .led_line_b(led_line_b), .led_enable_switch(led_enable_switch), .led_a_on(led_a_on),
    .led_b_on(led_b_on), .io_oe(io_oe), .status(status), .mode(mode));
  bss_loader_model i_bss_loader_model (.sys_clk(sys_clk), .status(status), .fail_cmd(fail_cmd),
    .load_cmd(load_cmd), .boot_ok(boot_ok), .boot_fail(boot_fail), .serial_loaded(serial_loaded));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk_val(input string name, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog: all tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out();
  end
  initial
  begin
    rst_b = 1'b0;
    reset_in_low = 1'b1;
    led_line_a = 1'b0;
    led_line_b = 1'b0;
    led_enable_switch = 1'b0;
    foreach (rows[i])
    begin
      straps <= rows[i].st;
      fail_cmd <= rows[i].fl;
      load_cmd <= rows[i].ld;
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (30) @(posedge sys_clk);
      straps <= rows[i].st ^ 4'h9; // late strap change must not matter
      for (int n = 0; n < 300 && !(status.core_run || status.shutdown); n++) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
      chk_val("mode", {2'b00, rows[i].md}, {2'b00, mode});
      chk_val("status", rows[i].run ? 5'h02 : 5'h01, status);
      chk_val("io_oe", {4'h0, rows[i].run}, {4'h0, io_oe});
      $display("test row %0d done", i);
      @(posedge sys_clk);
      rst_b <= 1'b0;
    end
    // flash-only boot brought up to run, so the pin reset has driven lines to release
    @(posedge sys_clk);
    rst_b <= 1'b1;
    fail_cmd <= 1'b0;
    for (int n = 0; n < 300 && !status.core_run; n++) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    chk_val("status", 5'h02, status);
    chk_val("io_oe", 5'h01, {4'h0, io_oe});
    // external reset pin clears the run and holds boot off for the restart delay
    @(posedge sys_clk);
    reset_in_low <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_val("status", 5'h00, status);
    chk_val("io_oe", 5'h00, {4'h0, io_oe});
    @(posedge sys_clk);
    reset_in_low <= 1'b1;
    // restart of 20 cycles, one sample cycle, status one cycle behind the state
    repeat (21) @(posedge sys_clk);
    #1;
    chk_val("status", 5'h00, status);
    @(posedge sys_clk);
    #1;
    chk_val("status", 5'h08, status);
    $display("test reset pin done");
    // led lines driven actively, then power switched off
    @(posedge sys_clk);
    led_enable_switch <= 1'b1;
    led_line_a <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_val("led_a_on", 5'h01, {4'h0, led_a_on});
    chk_val("led_b_on", 5'h00, {4'h0, led_b_on});
    @(posedge sys_clk);
    led_line_b <= 1'b1;
    led_enable_switch <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_val("led_a_on", 5'h00, {4'h0, led_a_on});
    chk_val("led_b_on", 5'h00, {4'h0, led_b_on});
    // power back on: line b now high must light its led
    @(posedge sys_clk);
    led_enable_switch <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_val("led_b_on", 5'h01, {4'h0, led_b_on});
    $display("test leds done");
    close_out();
  end
endmodule
